// ### rtl/sbc_mode_ctrl.sv
`include "sbc_mode_params.svh"
module sbc_mode_ctrl
    import sbc_mode_pkg::*;
#(
    parameter int RESET_DUR_US = `RESET_DUR_US,
    parameter int NR_TIMEOUT_US = `NR_TIMEOUT_US,
    parameter int INT_PULSE_US = `INT_PULSE_US
) (
    input wire logic clk, // 125 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic cs_n_pin, // serial chip select pin, active low
    input wire logic vdd_ok, // supply above reset threshold (pin)
    input wire logic can_wake, // CAN wake detected (pin level)
    input wire logic [3:0] wake_inputs, // wake input lines (pin)
    input wire logic forced_wake, // forced wake timer expiry (pin)
    input wire logic stop_overcurrent, // above stop_overcurrent_threshold
    input wire logic can_rx_msg, // CAN message received (pin)
    input wire logic mode_wr, // mode_control_reg write, one cycle
    input wire sbc_mode_pkg::mode_code_t mode_code, // mode code of that write
    input wire logic timing_wr, // timing_subreg write, one cycle
    input wire logic window_select, // 1: window watchdog
    input wire logic period_sel_lo, // period field low bit
    input wire logic period_sel_hi, // period field high bit
    input wire logic rcr_wr, // reset_control_reg write, one cycle
    input wire logic stop_watchdog_enable, // data of that write
    output logic reset_out_n, // MCU reset, active low
    output logic watchdog_fault_out_n, // watchdog fault, active low
    output logic int_out_n, // interrupt pulse, active low
    output logic vdd_reg_en, // main regulator enable
    output logic aux_regulator_ctrl, // secondary regulator control
    output logic can_tx_en, // CAN transmit allowed
    output logic can_wake_flag, // sticky CAN wake source
    output logic [3:0] wake_input_flag, // sticky wake input source
    output logic serial_accept, // serial commands accepted
    output logic [2:0] mode_state // current mode for status reads
);
    import sbc_mode_pkg::*;
    localparam int TICK_CYC = `TICK_CYC;
    localparam int OC_DEG_US = `OC_DEGLITCH_US;
    localparam int FS_US = `FIRST_SERIAL_US;

    sbc_mode_e st_r, st_nxt;
    logic [1:0] cs_s_r, vdd_s_r, can_s_r, fw_s_r, oc_s_r, rx_s_r;
    logic [7:0] wk_s_r;
    logic cs_d_r;
    logic [6:0] tick_cnt_r;
    logic tick;
    logic from_sleep_r, win_r, wd_stop_r, fault_n_r, stop_pend_r;
    logic [1:0] per_r;
    logic can_flag_r;
    logic [3:0] wk_flag_r;
    logic [5:0] oc_deg_r;
    logic [5:0] fs_cnt_r;
    logic [3:0] pulse_cnt_r;
    logic int_n_r, rst_n_r, aux_r, vdd_en_r, tx_r, acc_r;

    // two-flop synchronisers on all pin inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_s_r <= 2'h3;
            vdd_s_r <= 2'h0;
            can_s_r <= 2'h0;
            fw_s_r <= 2'h0;
            oc_s_r <= 2'h0;
            rx_s_r <= 2'h0;
            wk_s_r <= 8'h00;
            cs_d_r <= 1'b1;
        end else begin
            cs_s_r <= {cs_s_r[0], cs_n_pin};
            vdd_s_r <= {vdd_s_r[0], vdd_ok};
            can_s_r <= {can_s_r[0], can_wake};
            fw_s_r <= {fw_s_r[0], forced_wake};
            oc_s_r <= {oc_s_r[0], stop_overcurrent};
            rx_s_r <= {rx_s_r[0], can_rx_msg};
            wk_s_r <= {wk_s_r[3:0], wake_inputs};
            cs_d_r <= cs_s_r[1];
        end
    end

    wire cs_rise = cs_s_r[1] && !cs_d_r;
    wire vdd_good = vdd_s_r[1];
    wire [3:0] wk_now = wk_s_r[7:4];

    // microsecond timebase
    assign tick = (tick_cnt_r == 7'(TICK_CYC - 1));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) tick_cnt_r <= 7'h0;
        else tick_cnt_r <= tick ? 7'h0 : tick_cnt_r + 7'h1;
    end

    // command qualification: ignored during the first-serial delay
    wire cmd_ok = acc_r;
    wire mode_cmd = mode_wr && cmd_ok;
    wire tim_cmd = timing_wr && cmd_ok;
    wire in_wd_mode = (st_r == ST_NORMAL) || (st_r == ST_STANDBY)
        || (st_r == ST_STOP && wd_stop_r);

    // watchdog period selection
    wire [18:0] per_us = (per_r == 2'h0) ? 19'(`WD_PER0_US) :
        (per_r == 2'h1) ? 19'(`WD_PER1_US) :
        (per_r == 2'h2) ? 19'(`WD_PER2_US) : 19'(`WD_PER3_US);
    // a clear restarts with the period it carries, not the stored one
    wire [1:0] per_wr = {period_sel_hi, period_sel_lo};
    wire [18:0] per_wr_us = (per_wr == 2'h0) ? 19'(`WD_PER0_US) :
        (per_wr == 2'h1) ? 19'(`WD_PER1_US) :
        (per_wr == 2'h2) ? 19'(`WD_PER2_US) : 19'(`WD_PER3_US);

    // one shared timer: reset duration, normal-request timeout, watchdog
    logic tmr_start, tmr_stop, tmr_run, tmr_done;
    logic [18:0] tmr_load, tmr_cnt;
    sbc_tick_timer u_tmr (
        .clk(clk),
        .rstn(rstn),
        .tick(tick),
        .start(tmr_start),
        .stop(tmr_stop),
        .load_us(tmr_load),
        .running(tmr_run),
        .done(tmr_done),
        .count(tmr_cnt)
    );

    // open window is the later half of the period
    wire closed_win = win_r && (tmr_cnt > {1'b0, per_us[18:1]});
    wire wd_bad = in_wd_mode && st_r != ST_STOP && tim_cmd
        && closed_win;
    wire wd_expire = in_wd_mode && tmr_done;
    wire wd_reset = wd_bad || wd_expire;
    wire nr_timeout = (st_r == ST_NREQ) && tmr_done;
    wire oc_wake = oc_s_r[1] && (oc_deg_r == 6'h0);
    wire host_wake = cs_rise;
    wire dev_wake = can_s_r[1] || (|wk_now) || fw_s_r[1];
    wire stop_wake = host_wake || dev_wake || oc_wake;
    wire sleep_wake = dev_wake || host_wake;

    // next mode and timer control
    always_comb begin
        st_nxt = st_r;
        tmr_start = 1'b0;
        tmr_stop = 1'b0;
        tmr_load = 19'(RESET_DUR_US);
        if (!vdd_good && st_r != ST_SLEEP) begin
            st_nxt = ST_RESET;
            tmr_start = 1'b1;
        end else begin
            unique case (st_r)
                ST_RESET: if (tmr_done) begin
                    st_nxt = ST_NREQ;
                    tmr_start = 1'b1;
                    tmr_load = 19'(NR_TIMEOUT_US);
                end
                ST_NREQ: if (tim_cmd) begin
                    st_nxt = ST_NORMAL;
                    tmr_start = 1'b1;
                    tmr_load = per_wr_us;
                end else if (nr_timeout) begin
                    st_nxt = from_sleep_r ? ST_SLEEP : ST_RESET;
                    tmr_start = !from_sleep_r;
                    tmr_stop = from_sleep_r;
                end
                ST_NORMAL, ST_STANDBY: if (wd_reset) begin
                    st_nxt = ST_RESET;
                    tmr_start = 1'b1;
                end else begin
                    if (tim_cmd) begin
                        tmr_start = 1'b1;
                        tmr_load = per_wr_us;
                    end
                    if (mode_cmd) begin
                        unique case (mode_code)
                            `MODE_CODE_NORMAL: st_nxt = ST_NORMAL;
                            `MODE_CODE_STANDBY: st_nxt = ST_STANDBY;
                            `MODE_CODE_SLEEP: begin
                                st_nxt = ST_SLEEP;
                                tmr_stop = 1'b1;
                            end
                            `MODE_CODE_STOP: ;
                        endcase
                    end
                    if (stop_pend_r && cs_rise) begin
                        st_nxt = ST_STOP;
                        tmr_stop = !wd_stop_r;
                    end
                end
                ST_STOP: if (wd_expire) begin
                    st_nxt = ST_RESET;
                    tmr_start = 1'b1;
                end else if (stop_wake) begin
                    st_nxt = ST_NREQ;
                    tmr_start = 1'b1;
                    tmr_load = 19'(NR_TIMEOUT_US);
                end
                ST_SLEEP: if (sleep_wake) begin
                    st_nxt = ST_RESET;
                    tmr_start = 1'b1;
                end
            endcase
        end
    end

    // mode register and per-mode bookkeeping
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_RESET;
            from_sleep_r <= 1'b0;
            stop_pend_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_r == ST_SLEEP && st_nxt == ST_RESET) from_sleep_r <= 1'b1;
            else if (st_nxt != ST_RESET && st_nxt != ST_NREQ)
                from_sleep_r <= 1'b0;
            // stop waits for the frame's closing chip-select edge
            if (mode_cmd && mode_code == `MODE_CODE_STOP
                && (st_r == ST_NORMAL || st_r == ST_STANDBY))
                stop_pend_r <= 1'b1;
            else if (cs_rise || st_nxt == ST_RESET) stop_pend_r <= 1'b0;
        end
    end

    // watchdog configuration; window mode is the reset default
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            win_r <= 1'b1;
            per_r <= 2'h0;
            wd_stop_r <= 1'b0;
            fault_n_r <= 1'b1;
        end else begin
            if (tim_cmd && !wd_bad) begin
                win_r <= window_select;
                per_r <= per_wr;
            end
            if (rcr_wr && cmd_ok) wd_stop_r <= stop_watchdog_enable;
            // a bad write sets the fault even though it is a timing write
            if (wd_reset) fault_n_r <= 1'b0;
            else if (tim_cmd && (st_r == ST_NREQ || in_wd_mode))
                fault_n_r <= 1'b1;
        end
    end

    // overcurrent deglitch, re-armed on every stop entry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) oc_deg_r <= 6'h0;
        else if (st_r != ST_STOP) oc_deg_r <= 6'(OC_DEG_US);
        else if (tick && oc_deg_r != 6'h0) oc_deg_r <= oc_deg_r - 6'h1;
    end

    // wake source flags; set wins over clear by timing write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            can_flag_r <= 1'b0;
            wk_flag_r <= 4'h0;
        end else begin
            if ((st_r == ST_STOP || st_r == ST_SLEEP) && can_s_r[1])
                can_flag_r <= 1'b1;
            else if (st_r == ST_STANDBY && rx_s_r[1])
                can_flag_r <= 1'b1;
            else if (tim_cmd) can_flag_r <= 1'b0;
            if (st_r == ST_STOP || st_r == ST_SLEEP)
                wk_flag_r <= wk_flag_r | wk_now;
            else if (tim_cmd) wk_flag_r <= 4'h0;
        end
    end

    // interrupt pulse then first-serial delay after a stop wake
    wire stop_to_nreq = (st_r == ST_STOP) && (st_nxt == ST_NREQ);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt_r <= 4'h0;
            fs_cnt_r <= 6'h0;
            int_n_r <= 1'b1;
            acc_r <= 1'b1;
        end else begin
            if (stop_to_nreq) begin
                pulse_cnt_r <= 4'(INT_PULSE_US);
                int_n_r <= 1'b0;
                acc_r <= 1'b0;
            end else if (!int_n_r) begin
                if (tick) pulse_cnt_r <= pulse_cnt_r - 4'h1;
                if (tick && pulse_cnt_r == 4'h1) begin
                    int_n_r <= 1'b1;
                    fs_cnt_r <= 6'(FS_US);
                end
            end else if (!acc_r && tick) begin
                fs_cnt_r <= fs_cnt_r - 6'h1;
                if (fs_cnt_r <= 6'h1) acc_r <= 1'b1;
            end
        end
    end

    // outputs registered from the next mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_n_r <= 1'b0;
            vdd_en_r <= 1'b1;
            aux_r <= 1'b0;
            tx_r <= 1'b0;
        end else begin
            rst_n_r <= (st_nxt != ST_RESET) && (st_nxt != ST_SLEEP)
                && vdd_good;
            vdd_en_r <= (st_nxt != ST_SLEEP);
            aux_r <= (st_nxt == ST_NORMAL);
            tx_r <= (st_nxt == ST_NORMAL);
        end
    end

    assign reset_out_n = rst_n_r;
    assign watchdog_fault_out_n = fault_n_r;
    assign int_out_n = int_n_r;
    assign vdd_reg_en = vdd_en_r;
    assign aux_regulator_ctrl = aux_r;
    assign can_tx_en = tx_r;
    assign can_wake_flag = can_flag_r;
    assign wake_input_flag = wk_flag_r;
    assign serial_accept = acc_r;
    assign mode_state = st_r;

    // outputs mirror the mode register, so they are checked in the same cycle
    AST_STANDBY_AUX_OFF: assert property (@(posedge clk)
        disable iff (!rstn) st_r == ST_STANDBY |-> !aux_regulator_ctrl)
        else $error("aux regulator on in standby");
    AST_RESET_LOW: assert property (@(posedge clk)
        disable iff (!rstn) st_r == ST_RESET |-> !reset_out_n)
        else $error("reset output high in reset mode");
    AST_SLEEP_REG_OFF: assert property (@(posedge clk)
        disable iff (!rstn) st_r == ST_SLEEP |-> !vdd_reg_en)
        else $error("main regulator on in sleep");
    AST_STOP_WAKE_INT: assert property (@(posedge clk)
        disable iff (!rstn) stop_to_nreq |=> !int_out_n && st_r == ST_NREQ)
        else $error("no interrupt on stop wake");
    AST_CMD_BLOCKED: assert property (@(posedge clk)
        disable iff (!rstn) !int_out_n |-> !serial_accept)
        else $error("serial accepted during wake pulse");
    AST_STOP_AT_CS: assert property (@(posedge clk)
        disable iff (!rstn) (st_r != ST_STOP && st_nxt == ST_STOP)
        |-> cs_rise)
        else $error("stop entered without chip select rise");
    AST_CLOSED_RESET: assert property (@(posedge clk)
        disable iff (!rstn) wd_bad |=> st_r == ST_RESET && !fault_n_r)
        else $error("closed window write did not reset");
    AST_FAULT_LOW: assert property (@(posedge clk)
        disable iff (!rstn) wd_reset |=> ##1 !watchdog_fault_out_n)
        else $error("fault output not low after watchdog reset");
    AST_OC_DEGLITCH: assert property (@(posedge clk)
        disable iff (!rstn) $rose(st_r == ST_STOP) |-> !oc_wake[*8])
        else $error("overcurrent wake inside deglitch");
    AST_SLEEP_RETURN: assert property (@(posedge clk)
        disable iff (!rstn) nr_timeout && from_sleep_r && vdd_good
        && !tim_cmd |=> st_r == ST_SLEEP)
        else $error("no return to sleep");

    COV_STOP_WAKE: cover property (@(posedge clk) disable iff (!rstn)
        stop_to_nreq);
    COV_NR_TIMEOUT: cover property (@(posedge clk) disable iff (!rstn)
        nr_timeout);
    COV_CLOSED_WIN: cover property (@(posedge clk) disable iff (!rstn)
        wd_bad);
endmodule

// ### rtl/sbc_mode_params.svh
`ifndef SBC_MODE_PARAMS_SVH
`define SBC_MODE_PARAMS_SVH
// timebase: one tick per microsecond at 125 MHz
`define CLK_PERIOD_NS 8
`define TICK_NS 1000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
// times in microseconds
`define NR_TIMEOUT_US 350000
`define RESET_DUR_US 15000
`define INT_PULSE_US 10
`define FIRST_SERIAL_US 50
`define OC_DEGLITCH_US 40
// watchdog periods in microseconds, selected by the two-bit field
`define WD_PER0_US 10000
`define WD_PER1_US 45000
`define WD_PER2_US 100000
`define WD_PER3_US 350000
// mode codes carried by a mode control write
`define MODE_CODE_SLEEP 2'h0
`define MODE_CODE_STOP 2'h1
`define MODE_CODE_NORMAL 2'h2
`define MODE_CODE_STANDBY 2'h3
`endif

// ### rtl/sbc_mode_pkg.sv
package sbc_mode_pkg;
    typedef enum logic [2:0] {
        ST_RESET, ST_NREQ, ST_NORMAL, ST_STANDBY, ST_STOP, ST_SLEEP
    } sbc_mode_e;
    typedef logic [1:0] mode_code_t;
endpackage

// ### rtl/sbc_tick_timer.sv
// microsecond down-counter; loads on start, flags done when it reaches zero
module sbc_tick_timer (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic tick, // one-microsecond strobe
    input wire logic start, // load and run
    input wire logic stop, // halt, count kept
    input wire logic [18:0] load_us, // start value in microseconds
    output logic running, // counting
    output logic done, // one-cycle pulse at expiry
    output logic [18:0] count // remaining microseconds
);
    logic [18:0] count_r;
    logic run_r;
    logic done_r;
    assign running = run_r;
    assign done = done_r;
    assign count = count_r;

    // restart beats stop so a reload in the same cycle is not lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_r <= 19'h0;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                count_r <= load_us;
                run_r <= 1'b1;
            end else if (stop) begin
                run_r <= 1'b0;
            end else if (run_r && tick) begin
                if (count_r <= 19'h1) begin
                    run_r <= 1'b0;
                    done_r <= 1'b1;
                    count_r <= 19'h0;
                end else begin
                    count_r <= count_r - 19'h1;
                end
            end
        end
    end
endmodule

// ### tb/host_mcu_model.sv
// host side of the serial link: frames, strobes, chip-select wake
module host_mcu_model (
    input wire logic clk, // system clock
    input wire logic serial_accept, // device takes commands
    output logic cs_n_pin, // chip select, active low
    output logic mode_wr, // mode write strobe
    output sbc_mode_pkg::mode_code_t mode_code, // mode code
    output logic timing_wr, // timing write strobe
    output logic window_select, // window watchdog
    output logic period_sel_lo, // period low bit
    output logic period_sel_hi, // period high bit
    output logic rcr_wr, // reset control write strobe
    output logic stop_watchdog_enable // stop watchdog data
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_mode_pkg::*;

    // idle: no frame open, no strobe
    initial begin
        cs_n_pin = 1'b1;
        {mode_wr, timing_wr, rcr_wr} = 3'h0;
        mode_code = 2'h0;
        {window_select, period_sel_hi, period_sel_lo} = 3'h0;
        stop_watchdog_enable = 1'b0;
    end

    // one frame, one strobe; kind 0 mode, 1 timing, 2 reset control
    task automatic frame(input logic [1:0] kind, input logic [2:0] dat,
                         input logic hold);
        int n;
        n = 0;
        // quiet time after a wake pulse must be waited out
        while (serial_accept !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        cs_n_pin <= 1'b0;
        @(posedge clk);
        mode_wr <= (kind == 2'h0);
        timing_wr <= (kind == 2'h1);
        rcr_wr <= (kind == 2'h2);
        mode_code <= dat[1:0];
        {window_select, period_sel_hi, period_sel_lo} <= dat;
        stop_watchdog_enable <= dat[0];
        @(posedge clk);
        {mode_wr, timing_wr, rcr_wr} <= 3'h0;
        // data is stale once the strobe drops, so show its inverse
        mode_code <= ~dat[1:0];
        {window_select, period_sel_hi, period_sel_lo} <= ~dat;
        stop_watchdog_enable <= ~dat[0];
        repeat (4) @(posedge clk);
        if (!hold) cs_n_pin <= 1'b1;
    endtask

    // close a held frame, or wake the device by a bare low-high edge
    task automatic cs_rise();
        @(posedge clk);
        cs_n_pin <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n_pin <= 1'b1;
    endtask
endmodule

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_mode_pkg::*;
    localparam int US = 125; // clock cycles per microsecond
    logic clk, rstn, vdd_ok, can_wake, forced_wake, stop_overcurrent;
    logic can_rx_msg;
    logic [3:0] wake_inputs, wake_input_flag;
    logic cs_n_pin, mode_wr, timing_wr, window_select, period_sel_lo;
    logic period_sel_hi, rcr_wr, stop_watchdog_enable, reset_out_n;
    logic watchdog_fault_out_n, int_out_n, vdd_reg_en, aux_regulator_ctrl;
    logic can_tx_en, can_wake_flag, serial_accept;
    logic [2:0] mode_state;
    mode_code_t mode_code;
    int fails, checks_done;
    int cyc = 0;

    // short counts keep the run small; expectations scale with them
    sbc_mode_ctrl #(.RESET_DUR_US(20), .NR_TIMEOUT_US(100),
        .INT_PULSE_US(10)) dut_u (
        .clk(clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .vdd_ok(vdd_ok),
        .can_wake(can_wake), .wake_inputs(wake_inputs),
        .forced_wake(forced_wake), .stop_overcurrent(stop_overcurrent),
        .can_rx_msg(can_rx_msg), .mode_wr(mode_wr), .mode_code(mode_code),
        .timing_wr(timing_wr), .window_select(window_select),
        .period_sel_lo(period_sel_lo), .period_sel_hi(period_sel_hi),
        .rcr_wr(rcr_wr), .stop_watchdog_enable(stop_watchdog_enable),
        .reset_out_n(reset_out_n),
        .watchdog_fault_out_n(watchdog_fault_out_n),
        .int_out_n(int_out_n), .vdd_reg_en(vdd_reg_en),
        .aux_regulator_ctrl(aux_regulator_ctrl), .can_tx_en(can_tx_en),
        .can_wake_flag(can_wake_flag), .wake_input_flag(wake_input_flag),
        .serial_accept(serial_accept), .mode_state(mode_state));

    host_mcu_model host_u (
        .clk(clk), .serial_accept(serial_accept), .cs_n_pin(cs_n_pin),
        .mode_wr(mode_wr), .mode_code(mode_code), .timing_wr(timing_wr),
        .window_select(window_select), .period_sel_lo(period_sel_lo),
        .period_sel_hi(period_sel_hi), .rcr_wr(rcr_wr),
        .stop_watchdog_enable(stop_watchdog_enable));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // bounded wait for a mode; a miss shows up as a mismatch
    task automatic wait_mode(input logic [2:0] m, input int lim);
        int n;
        n = 0;
        while (mode_state !== m && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk(8'(mode_state), 8'(m));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic t_power();
        repeat (16) @(posedge clk);
        chk(8'({reset_out_n, watchdog_fault_out_n, int_out_n, mode_state}),
            8'h18);
        @(posedge clk) rstn <= 1'b1;
        repeat (20 * US - 40) @(posedge clk);
        chk(8'(mode_state), 8'(ST_RESET));
        wait_mode(ST_NREQ, 100);
        repeat (2) @(posedge clk);
        chk(8'(reset_out_n), 8'h01);
        $display("power-up test done");
    endtask

    task automatic t_nr_timeout();
        repeat (100 * US - 60) @(posedge clk);
        chk(8'(mode_state), 8'(ST_NREQ));
        wait_mode(ST_RESET, 150);
        chk(8'({reset_out_n, watchdog_fault_out_n}), 8'h01);
        wait_mode(ST_NREQ, 21 * US);
        $display("request timeout test done");
    endtask

    task automatic t_modes();
        host_u.frame(2'h1, 3'h4, 1'b0);
        host_u.frame(2'h0, 3'h2, 1'b0);
        wait_mode(ST_NORMAL, 20);
        chk(8'({vdd_reg_en, aux_regulator_ctrl, can_tx_en}), 8'h07);
        host_u.frame(2'h0, 3'h3, 1'b0);
        wait_mode(ST_STANDBY, 20);
        chk(8'({vdd_reg_en, aux_regulator_ctrl, can_tx_en}), 8'h04);
        @(posedge clk) can_rx_msg <= 1'b1;
        repeat (6) @(posedge clk);
        can_rx_msg <= 1'b0;
        chk(8'(can_wake_flag), 8'h01);
        $display("mode test done");
    endtask

    // a clear in the closed window resets and latches the fault
    task automatic t_closed();
        host_u.frame(2'h1, 3'h4, 1'b0);
        wait_mode(ST_RESET, 20);
        chk(8'({reset_out_n, watchdog_fault_out_n}), 8'h00);
        wait_mode(ST_NREQ, 21 * US);
        chk(8'(watchdog_fault_out_n), 8'h00);
        host_u.frame(2'h1, 3'h0, 1'b0);
        repeat (3) @(posedge clk);
        chk(8'(watchdog_fault_out_n), 8'h01);
        host_u.frame(2'h0, 3'h2, 1'b0);
        wait_mode(ST_NORMAL, 20);
        host_u.frame(2'h1, 3'h0, 1'b0);
        repeat (5) @(posedge clk);
        chk(8'(mode_state), 8'(ST_NORMAL));
        $display("window test done");
    endtask

    // sources: can, wake input, forced, chip select, overcurrent
    task automatic t_stop();
        int n;
        for (int i = 0; i < 5; i++) begin
            host_u.frame(2'h1, 3'h0, 1'b0);
            host_u.frame(2'h2, 3'h0, 1'b0);
            host_u.frame(2'h0, 3'h1, 1'b1);
            repeat (4) @(posedge clk);
            chk(8'(mode_state), 8'(ST_NORMAL));
            host_u.cs_rise();
            wait_mode(ST_STOP, 10);
            @(posedge clk);
            case (i)
                0: can_wake <= 1'b1;
                1: wake_inputs <= 4'h2;
                2: forced_wake <= 1'b1;
                4: stop_overcurrent <= 1'b1;
                default: host_u.cs_rise();
            endcase
            if (i == 4) begin
                repeat (20 * US) @(posedge clk);
                chk(8'(mode_state), 8'(ST_STOP));
            end
            wait_mode(ST_NREQ, 40 * US);
            chk(8'({int_out_n, serial_accept}), 8'h00);
            chk(8'({can_wake_flag, wake_input_flag}),
                8'(i == 0 ? 5'h10 : i == 1 ? 5'h02 : 5'h00));
            {can_wake, forced_wake, stop_overcurrent} <= 3'h0;
            wake_inputs <= 4'h0;
            n = 0;
            while (int_out_n !== 1'b1 && n < 2000) begin
                @(posedge clk);
                n++;
            end
            #1;
            // pulse spans ten timebase ticks; first tick phase is free
            chk(8'(n > 9 * US && n <= 10 * US), 8'h01);
            chk(8'(serial_accept), 8'h00);
            host_u.frame(2'h1, 3'h0, 1'b0);
            host_u.frame(2'h0, 3'h2, 1'b0);
            wait_mode(ST_NORMAL, 20);
        end
        $display("stop wake test done");
    endtask

    task automatic t_sleep();
        host_u.frame(2'h0, 3'h0, 1'b1);
        wait_mode(ST_SLEEP, 20);
        chk(8'({vdd_reg_en, aux_regulator_ctrl}), 8'h00);
        host_u.cs_rise();
        wait_mode(ST_RESET, 20);
        wait_mode(ST_NREQ, 21 * US);
        wait_mode(ST_SLEEP, 101 * US);
        @(posedge clk) can_wake <= 1'b1;
        wait_mode(ST_RESET, 20);
        @(posedge clk) can_wake <= 1'b0;
        wait_mode(ST_NREQ, 21 * US);
        $display("sleep test done");
    endtask

    // supply low holds reset past the reset duration, fault stays high
    task automatic t_vdd();
        @(posedge clk) vdd_ok <= 1'b0;
        wait_mode(ST_RESET, 10);
        chk(8'({reset_out_n, watchdog_fault_out_n}), 8'h01);
        repeat (30 * US) @(posedge clk);
        chk(8'(reset_out_n), 8'h00);
        vdd_ok <= 1'b1;
        wait_mode(ST_NREQ, 21 * US);
        $display("supply test done");
    endtask

    initial begin
        rstn = 1'b0;
        vdd_ok = 1'b1;
        {can_wake, forced_wake, stop_overcurrent, can_rx_msg} = 4'h0;
        wake_inputs = 4'h0;
        fails = 0;
        checks_done = 0;
        t_power();
        t_nr_timeout();
        t_modes();
        t_closed();
        t_stop();
        t_sleep();
        t_vdd();
        tally_and_finish();
    end

    // hang guard, sized above the longest expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fails++;
            tally_and_finish();
        end
    end
endmodule
